// ### include/swt_pkg.sv
// Package for the stabilization and watchdog timer
// Assumes an APB slave with 32-bit data, one register per word
package swt_pkg;

    // =========================================================
    // Register map (printed offsets are register indices)
    localparam logic [7:0] SWT_IDX_CONTROL = 8'hd3;
    localparam logic [7:0] SWT_IDX_COUNT = 8'hfd;
    localparam logic [7:0] SWT_IDX_STATUS = 8'hfe;
    localparam logic [11:0] SWT_ADDR_CONTROL = {2'h0, SWT_IDX_CONTROL, 2'h0};
    localparam logic [11:0] SWT_ADDR_COUNT = {2'h0, SWT_IDX_COUNT, 2'h0};
    localparam logic [11:0] SWT_ADDR_STATUS = {2'h0, SWT_IDX_STATUS, 2'h0};

    // =========================================================
    // Control fields and reset values
    localparam logic [7:0] SWT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SWT_COUNT_RESET = 8'h00;
    localparam int SWT_KEY_LSB = 4;
    localparam logic [3:0] SWT_KEY_DISABLE = 4'ha;
    localparam int SWT_SEL_LSB = 2;
    localparam int SWT_CNT_CLR_BIT = 1;
    localparam int SWT_DIV_CLR_BIT = 0;

    // Divide ratio selection
    localparam logic [1:0] SWT_SEL_DIV4096 = 2'h0;
    localparam logic [1:0] SWT_SEL_DIV1024 = 2'h1;
    localparam logic [1:0] SWT_SEL_DIV128 = 2'h2;

    // Divider taps: tick when low bits of divider wrap
    localparam int SWT_DIV_WIDTH = 12;
    localparam logic [11:0] SWT_DIV4096_MASK = 12'hfff;
    localparam logic [11:0] SWT_DIV1024_MASK = 12'h3ff;
    localparam logic [11:0] SWT_DIV128_MASK = 12'h07f;

    // Timer modes: run, or stabilization after reset or wake
    typedef enum logic [1:0] {
        SWT_RUN,
        SWT_STAB_RESET,
        SWT_STAB_WAKE
    } swt_mode_t;

endpackage : swt_pkg

// ### logic/swt_prescaler.sv
// Free-running oscillator prescaler with selectable tap
// Assumes it runs on the oscillator clock and a synchronous clear input
`timescale 1ns/100ps
module swt_prescaler (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic [1:0] sel,
    output logic tick
);

    logic [11:0] div_q;
    logic [11:0] div_d;
    logic [11:0] mask;

    // =========================================================
    // Tap selection
    always_comb
    begin
        case (sel)
            swt_pkg::SWT_SEL_DIV1024: mask = swt_pkg::SWT_DIV1024_MASK;
            swt_pkg::SWT_SEL_DIV128: mask = swt_pkg::SWT_DIV128_MASK;
            default: mask = swt_pkg::SWT_DIV4096_MASK;
        endcase
        div_d = clear ? 12'h000 : div_q + 12'h001;
        tick = ~clear && ((div_q & mask) == mask);
    end

    // Divider register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            div_q <= 12'h000;
        else
            div_q <= div_d;
    end

endmodule : swt_prescaler

// ### logic/swt_timer.sv
// Stabilization and watchdog timer, APB register slave
// Assumes clk_sys is the oscillator clock, arst_n is system reset,
// and stop_wake comes asynchronously from the wake-up logic.
//
// How it works
// - Oscillator clock divided by 4096, 1024 or 128 feeds the counter.
// - Eight-bit up-counter on divided clock, readable, writes ignored.
// - Reset zeroes control: watchdog on, divide by 4096 selected.
// - Watchdog off only while control upper nibble equals 1010.
// - Writing one to control bit 1 clears the counter.
// - Writing one to control bit 0 clears the divider.
// - Enabled watchdog resets system on counter overflow out of bit 7.
// - Stop-mode release by reset or interrupt starts the stabilization count.
// - After reset count at /4096; after wake use selected rate.
// - Counter bit 7 set ends stabilization and lets CPU clock run.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module swt_timer (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_wake,
    output logic wdt_reset_req,
    output logic cpu_clk_en,
    output logic stab_done
);

    // =========================================================
    // Declarations
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic wdt_q;
    logic wdt_d;
    swt_pkg::swt_mode_t mode_q;
    swt_pkg::swt_mode_t mode_d;
    logic wake_s1_q;
    logic wake_s2_q;
    logic wake_s3_q;
    logic wr_en;
    logic rd_en;
    logic div_clear;
    logic tick;
    logic [1:0] sel_eff;
    logic wdt_enabled;
    logic overflow;
    logic cnt_clear;

    // =========================================================
    // Address decode helper
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == swt_pkg::SWT_ADDR_CONTROL) || (a == swt_pkg::SWT_ADDR_COUNT)
            || (a == swt_pkg::SWT_ADDR_STATUS);
    endfunction : is_mapped

    // =========================================================
    // APB strobes, zero wait state
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = rdata_q;

    // =========================================================
    // Wake request synchroniser and edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= stop_wake;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // =========================================================
    // Prescaler
    // Reset stabilization forces the slowest tap
    assign sel_eff = (mode_q == swt_pkg::SWT_STAB_RESET) ? swt_pkg::SWT_SEL_DIV4096
        : ctrl_q[swt_pkg::SWT_SEL_LSB +: 2];
    assign div_clear = wr_en && (paddr == swt_pkg::SWT_ADDR_CONTROL)
        && pwdata[swt_pkg::SWT_DIV_CLR_BIT];

    swt_prescaler i_swt_prescaler (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(div_clear),
        .sel(sel_eff),
        .tick(tick)
    );

    // =========================================================
    // Watchdog enable and overflow
    assign wdt_enabled = ctrl_q[7:swt_pkg::SWT_KEY_LSB] != swt_pkg::SWT_KEY_DISABLE;
    assign overflow = tick && (cnt_q == 8'hff);
    assign cnt_clear = wr_en && (paddr == swt_pkg::SWT_ADDR_CONTROL)
        && pwdata[swt_pkg::SWT_CNT_CLR_BIT];

    // =========================================================
    // Control register next value; clear bits self-clearing
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_en && (paddr == swt_pkg::SWT_ADDR_CONTROL))
            ctrl_d = {pwdata[7:2], 2'h0};
    end

    // =========================================================
    // Counter, mode and watchdog next values
    always_comb
    begin
        cnt_d = cnt_q;
        mode_d = mode_q;
        wdt_d = 1'b0;
        if (wake_s2_q && !wake_s3_q && (mode_q == swt_pkg::SWT_RUN))
        begin
            mode_d = swt_pkg::SWT_STAB_WAKE;
            cnt_d = 8'h00;
        end
        else
        begin
            if (cnt_clear)
                cnt_d = 8'h00;
            else if (tick)
                cnt_d = cnt_q + 8'h01;
            if (mode_q != swt_pkg::SWT_RUN && cnt_q[7])
                mode_d = swt_pkg::SWT_RUN;
            if (overflow && wdt_enabled && mode_q == swt_pkg::SWT_RUN && !cnt_clear)
                wdt_d = 1'b1;
        end
    end

    // =========================================================
    // Read data mux, registered at setup phase
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_en)
        begin
            case (paddr)
                swt_pkg::SWT_ADDR_CONTROL: rdata_d = {24'h000000, ctrl_q};
                swt_pkg::SWT_ADDR_COUNT: rdata_d = {24'h000000, cnt_q};
                swt_pkg::SWT_ADDR_STATUS: rdata_d = {29'h0, wdt_enabled, stab_done, cpu_clk_en};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // =========================================================
    // State registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= swt_pkg::SWT_CONTROL_RESET;
            cnt_q <= swt_pkg::SWT_COUNT_RESET;
            mode_q <= swt_pkg::SWT_STAB_RESET;
            wdt_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            wdt_q <= wdt_d;
            rdata_q <= rdata_d;
        end
    end

    // =========================================================
    // Outputs
    assign wdt_reset_req = wdt_q;
    assign cpu_clk_en = (mode_q == swt_pkg::SWT_RUN);
    assign stab_done = (mode_q == swt_pkg::SWT_RUN);

endmodule : swt_timer

// ### verif/swt_timer_checker.sv
// Checker of the timer's bus and status ports
// Assumes it is bound onto swt_timer, sharing its clock and reset
`timescale 1ns/100ps
module swt_timer_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_wake,
    input wire logic wdt_reset_req,
    input wire logic cpu_clk_en,
    input wire logic stab_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // =====================================================
    // Access decode and last written key nibble
    logic acc, rd, map;
    logic [3:0] key_q, key_d;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign map = paddr inside {swt_pkg::SWT_ADDR_CONTROL, swt_pkg::SWT_ADDR_COUNT, swt_pkg::SWT_ADDR_STATUS};
    // Key follows control writes
    always_comb
        key_d = (acc && pwrite && paddr == swt_pkg::SWT_ADDR_CONTROL) ? pwdata[7:4] : key_q;
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            key_q <= 4'h0;
        else
            key_q <= key_d;
    // =====================================================
    // Properties
    AST_READY: assert property (acc |-> pready) else $error("pready low in access");
    AST_UNMAP_ERR: assert property (acc && !map |-> pslverr) else $error("no slverr unmapped");
    AST_MAP_OK: assert property (acc && map |-> !pslverr) else $error("slverr on mapped");
    AST_UNMAP_ZERO: assert property (rd && !map |-> prdata == 32'h0) else $error("unmapped read nonzero");
    AST_CTL_READ: assert property (rd && paddr == swt_pkg::SWT_ADDR_CONTROL |->
        prdata[7:4] == key_q && prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0) else $error("control readback");
    AST_KEY_STATUS: assert property (rd && paddr == swt_pkg::SWT_ADDR_STATUS |->
        prdata[2] == (key_q != swt_pkg::SWT_KEY_DISABLE)) else $error("watchdog enable wrong");
    AST_WDT_PULSE: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("reset request too long");
    AST_WDT_STAB: assert property (!cpu_clk_en |-> !wdt_reset_req) else $error("reset request in stab");
    AST_STAB_PAIR: assert property (stab_done == cpu_clk_en) else $error("stab flags differ");
    AST_REL_HOLD: assert property ($rose(arst_n) |-> !cpu_clk_en [*8]) else $error("clock early after reset");
endmodule : swt_timer_checker

bind swt_timer swt_timer_checker i_swt_timer_checker (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .stop_wake, .wdt_reset_req, .cpu_clk_en, .stab_done);

// ### verif/swt_timer_tb_top.sv
// Self-checking bench for the stabilization and watchdog timer
// Assumes swt_timer with its checker bound in the checker file
`timescale 1ns/100ps
module swt_timer_tb_top;
    localparam logic [11:0] CTL = swt_pkg::SWT_ADDR_CONTROL;
    localparam logic [11:0] CNT = swt_pkg::SWT_ADDR_COUNT;
    localparam logic [11:0] STA = swt_pkg::SWT_ADDR_STATUS;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_wake = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, serr, wdt_reset_req, cpu_clk_en, stab_done;
    int err_count = 0;
    int compares = 0;
    // Write value, control readback, status readback
    logic [23:0] rows [6] = '{24'ha0a000, 24'hb0b004, 24'h505004, 24'ha4a400, 24'hacac00, 24'h0f0c04};
    swt_timer i_swt_timer (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .stop_wake, .wdt_reset_req, .cpu_clk_en, .stab_done);
    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, waits for pready; only the hang guard ends a stuck wait
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer
    // Read and compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rchk
    // Verdict
    task automatic end_sim;
        $display("Compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // Hang guard
    initial
    begin
        #200000;
        err_count++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i])
        begin
            xfer(1'b1, CTL, {24'h0, rows[i][23:16]});
            rchk(CTL, {24'h0, rows[i][15:8]});
            rchk(STA, {24'h0, rows[i][7:0]});
        end
        $display("Test rows done");
        xfer(1'b1, CTL, 32'h0b);
        repeat (1000) @(posedge clk_sys);
        rchk(CNT, 32'h0);
        repeat (3200) @(posedge clk_sys);
        rchk(CNT, 32'h1);
        xfer(1'b1, CTL, 32'h02);
        xfer(1'b1, CNT, 32'hff);
        rchk(CNT, 32'h0);
        $display("Test counter done");
        xfer(1'b1, 12'h000, 32'ha0);
        chk({31'h0, serr}, 32'h1);
        rchk(12'h000, 32'h0);
        chk({31'h0, serr}, 32'h1);
        rchk(CTL, 32'h0);
        stop_wake <= 1'b1;
        repeat (20) @(posedge clk_sys);
        stop_wake <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk({30'h0, cpu_clk_en, wdt_reset_req}, 32'h0);
        $display("Test unmapped and wake done");
        xfer(1'b1, CTL, 32'ha8);
        arst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({30'h0, cpu_clk_en, wdt_reset_req}, 32'h0);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rchk(CTL, 32'h0);
        rchk(STA, 32'h4);
        rchk(CNT, 32'h0);
        $display("Test reset done");
        end_sim();
    end
endmodule : swt_timer_tb_top
